// ### core/transmit_merge_unit.sv
// Four-to-one transmit packet merge unit toward one MAC stream port
`default_nettype none
module transmit_merge_unit
    import tmu_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Source side
    input wire logic [TMU_NUM_SRC-1:0] source_word_valid,
    input wire tmu_word_t [TMU_NUM_SRC-1:0] source_word,
    output logic [TMU_NUM_SRC-1:0] source_word_accept,
    // MAC side
    output logic mac_tx_valid,
    input wire logic mac_tx_ready,
    output logic [TMU_DATA_W-1:0] mac_tx_data,
    output logic mac_tx_last,
    // Observation
    output logic [TMU_CH_W-1:0] active_channel_select
);

    // ==========================================================
    // State
    tmu_state_t state_q, state_d;
    logic [TMU_CH_W-1:0] ch_q, ch_d;
    logic [TMU_NUM_SRC-1:0] accept_q, accept_d;
    logic out_valid_q, out_valid_d;
    tmu_word_t out_word_q, out_word_d;
    tmu_word_t pending_word_latch_q, pending_word_latch_d;
    logic pend_full_q, pend_full_d;

    // ==========================================================
    // Working signals
    logic pick_found;
    logic [TMU_CH_W-1:0] pick_ch;
    logic take;
    logic take_last;
    logic out_free;
    logic stall;
    tmu_word_t act_word;

    // ==========================================================
    // Arbiter
    // cyclic nearest pick
    tmu_rr_pick i_tmu_rr_pick (
        .req(source_word_valid),
        .cur(ch_q),
        .found(pick_found),
        .pick(pick_ch)
    );

    // ==========================================================
    // Handshake terms
    // Active word is a plain mux; only the accepted one is used
    assign act_word = source_word[ch_q];
    assign take = source_word_valid[ch_q] & accept_q[ch_q];
    assign take_last = take & act_word.last;
    // Stall uses the registered valid, so an empty output never stalls
    assign stall = out_valid_q & ~mac_tx_ready;
    assign out_free = ~stall;

    // ==========================================================
    // Channel select and packet state
    // One dead idle cycle between packets; short packets lose line rate
    always_comb begin
        state_d = state_q;
        ch_d = ch_q;
        case (state_q)
            TMU_ST_IDLE: begin
                if (pick_found) begin
                    state_d = TMU_ST_PACKET;
                    ch_d = pick_ch;
                end
            end
            TMU_ST_PACKET: begin
                if (take_last) begin
                    state_d = TMU_ST_IDLE;
                end
            end
            default: begin
                state_d = TMU_ST_IDLE;
            end
        endcase
    end

    // ==========================================================
    // Output register, latch and accept
    // The latch costs one word of storage but lets accept be a flop
    always_comb begin
        out_valid_d = out_valid_q;
        out_word_d = out_word_q;
        pending_word_latch_d = pending_word_latch_q;
        pend_full_d = pend_full_q;
        accept_d = TMU_ACCEPT_RESET;
        if (take) begin
            pending_word_latch_d = act_word;
        end
        if (out_free) begin
            if (pend_full_q) begin
                out_word_d = pending_word_latch_q;
                out_valid_d = 1'b1;
                pend_full_d = take;
            end else if (take) begin
                out_word_d = act_word;
                out_valid_d = 1'b1;
            end else begin
                out_valid_d = 1'b0;
            end
        end else if (take) begin
            pend_full_d = 1'b1;
        end
        // Accept is registered, so it falls one cycle into a stall
        // accept the granted source
        if (state_d == TMU_ST_PACKET && !pend_full_d && !stall && !take_last) begin
            accept_d[ch_d] = 1'b1;
        end
    end

    // ==========================================================
    // Arbiter registers
    // Select starts at the last channel so channel 0 wins first
    // idle with a defined select
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= TMU_ST_IDLE;
            ch_q <= TMU_CH_RESET;
        end else begin
            state_q <= state_d;
            ch_q <= ch_d;
        end
    end

    // ==========================================================
    // Datapath registers
    // no valid, accept or parked word
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            accept_q <= TMU_ACCEPT_RESET;
            out_valid_q <= 1'b0;
            out_word_q <= TMU_WORD_RESET;
            pending_word_latch_q <= TMU_WORD_RESET;
            pend_full_q <= 1'b0;
        end else begin
            accept_q <= accept_d;
            out_valid_q <= out_valid_d;
            out_word_q <= out_word_d;
            pending_word_latch_q <= pending_word_latch_d;
            pend_full_q <= pend_full_d;
        end
    end

    // ==========================================================
    // Outputs, all straight from flops
    // one select drives the mux
    assign active_channel_select = ch_q;
    assign source_word_accept = accept_q;
    assign mac_tx_valid = out_valid_q;
    assign mac_tx_data = out_word_q.data;
    assign mac_tx_last = out_word_q.last;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    // Reference pick by rotation, not by the scan in the pick block,
    // so a slip shared by both cannot hide from the order checks
    function automatic logic [TMU_CH_W-1:0] nearest_after(
        input logic [TMU_NUM_SRC-1:0] req,
        input logic [TMU_CH_W-1:0] cur
    );
        logic [2*TMU_NUM_SRC-1:0] rot;
        logic [TMU_CH_W-1:0] res;
        rot = {req, req} >> ({1'b0, cur} + 3'h1);
        res = cur;
        // Lowest rotated bit is the nearest channel after cur
        for (int i = TMU_NUM_SRC - 1; i >= 0; i--) begin
            if (rot[i]) begin
                res = cur + TMU_CH_W'(i + 1);
            end
        end
        nearest_after = res;
    endfunction

    one_accept_a: assert property (
        $onehot0(accept_q) && (accept_q == 4'h0 || accept_q[ch_q])
    ) else $error("accept not on the single active channel");

    for (genvar g = 0; g < TMU_NUM_SRC; g++) begin : g_chan
        chan_accept_a: assert property (
            @(posedge clock) disable iff (!rst_n)
            accept_q[g] |-> ch_q == TMU_CH_W'(g) && state_q == TMU_ST_PACKET
        ) else $error("accept on a channel that does not hold the port");
    end

    idle_grant_a: assert property (
        state_q == TMU_ST_IDLE && |source_word_valid
        |=> state_q == TMU_ST_PACKET
            && (($past(source_word_valid) >> ch_q) & 4'h1) == 4'h1
    ) else $error("idle request not granted");

    nearest_next_a: assert property (
        state_q == TMU_ST_IDLE && source_word_valid[2'(ch_q + 2'h1)]
        |=> ch_q == $past(2'(ch_q + 2'h1))
    ) else $error("nearest next requester skipped");

    rr_order_a: assert property (
        state_q == TMU_ST_IDLE && |source_word_valid
        |=> ch_q == $past(nearest_after(source_word_valid, ch_q))
    ) else $error("grant skipped a nearer requester");

    grant_accept_a: assert property (
        state_q == TMU_ST_PACKET && !pend_full_q && !stall && !take_last
        |=> accept_q[ch_q] && $stable(ch_q)
    ) else $error("active source not accepted");

    forward_word_a: assert property (
        take && out_free && !pend_full_q
        |=> mac_tx_valid && mac_tx_data == $past(act_word.data)
            && mac_tx_last == $past(act_word.last)
    ) else $error("source word not forwarded");

    stall_hold_a: assert property (
        stall |=> mac_tx_valid && $stable(mac_tx_data) && $stable(mac_tx_last)
    ) else $error("MAC outputs changed during stall");

    stall_accept_a: assert property (
        stall |=> accept_q == 4'h0
    ) else $error("accept high one cycle into a stall");

    parked_block_a: assert property (
        pend_full_q |-> accept_q == 4'h0
    ) else $error("accept high while a word is parked");

    resume_latch_a: assert property (
        pend_full_q && out_free
        |=> mac_tx_valid && mac_tx_data == $past(pending_word_latch_q.data)
    ) else $error("resume not taken from latch");

    latch_capture_a: assert property (
        take |=> pending_word_latch_q == $past(act_word)
    ) else $error("latch missed an accepted word");

    last_release_a: assert property (
        take_last |=> state_q == TMU_ST_IDLE && accept_q == 4'h0
    ) else $error("packet end did not release channel");

    idle_quiet_a: assert property (
        state_q == TMU_ST_IDLE |-> accept_q == 4'h0
    ) else $error("accept high while no channel granted");

    packet_hold_a: assert property (
        state_q == TMU_ST_PACKET && !take_last |=> $stable(ch_q)
    ) else $error("channel changed inside a packet");

    // ==========================================================
    // Coverage of main scenarios
    stall_seen_c: cover property (take ##1 stall ##1 stall ##1 !stall);
    switch_seen_c: cover property (take_last ##1 state_q == TMU_ST_IDLE
                                   ##1 state_q == TMU_ST_PACKET);
    all_req_c: cover property (state_q == TMU_ST_IDLE && &source_word_valid);
    latch_used_c: cover property (pend_full_q && out_free);
    pair_req_c: cover property (state_q == TMU_ST_IDLE && $countones(source_word_valid) > 1);

endmodule
`default_nettype wire

// ### shared/tmu_pkg.sv
// Shared types and constants for the four-to-one transmit merge unit
`default_nettype none
package tmu_pkg;

    // ==========================================================
    // Widths and counts
    localparam int TMU_DATA_W = 64;
    localparam int TMU_NUM_SRC = 4;
    localparam int TMU_CH_W = 2;

    // ==========================================================
    // Reset values
    // Start just before channel 0 so channel 0 wins the first scan
    localparam logic [1:0] TMU_CH_RESET = 2'h3;
    localparam logic [3:0] TMU_ACCEPT_RESET = 4'h0;

    // ==========================================================
    // One word of a packet with its end-of-packet mark
    typedef struct packed {
        logic last;
        logic [TMU_DATA_W-1:0] data;
    } tmu_word_t;

    localparam tmu_word_t TMU_WORD_RESET = '{last: 1'b0, data: 64'h0};

    // ==========================================================
    // Arbiter state: waiting for a request, or inside a packet
    typedef enum logic [0:0] {
        TMU_ST_IDLE = 1'b0,
        TMU_ST_PACKET = 1'b1
    } tmu_state_t;

endpackage
`default_nettype wire

// ### core/tmu_rr_pick.sv
// Round-robin pick of the next requesting channel after the current one
`default_nettype none
module tmu_rr_pick
    import tmu_pkg::*;
(
    // Requests and the channel that last held the port
    input wire logic [TMU_NUM_SRC-1:0] req,
    input wire logic [TMU_CH_W-1:0] cur,
    // Result
    output logic found,
    output logic [TMU_CH_W-1:0] pick
);

    // ==========================================================
    // Channel at a given distance after the current one, wrapping
    function automatic logic [TMU_CH_W-1:0] step_ch(input logic [TMU_CH_W-1:0] c,
                                                     input logic [TMU_CH_W-1:0] k);
        step_ch = c + k;
    endfunction

    // ==========================================================
    // Scan from the farthest back to the nearest so the nearest wins;
    // distance four is the current channel itself, checked first so it has the lowest priority
    always_comb begin
        found = 1'b0;
        pick = cur;
        for (int k = TMU_NUM_SRC; k >= 1; k--) begin
            if (req[step_ch(cur, TMU_CH_W'(k))]) begin
                found = 1'b1;
                pick = step_ch(cur, TMU_CH_W'(k));
            end
        end
    end

endmodule
`default_nettype wire

// ### verification/tmu_mac_sink.sv
// Behavioural MAC receive side with optional stalls
`default_nettype none
module tmu_mac_sink
    import tmu_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Stall mode from the bench
    input wire logic slow,
    // Stream handshake
    input wire logic mac_tx_valid,
    output logic mac_tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ph_q;
    // ==========================================
    // Ready pattern
    // stream ready side
    // Slow mode keeps ready low two cycles in three to force stalls
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ph_q <= 2'h0;
            mac_tx_ready <= 1'b0;
        end else begin
            ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
            mac_tx_ready <= !slow || (ph_q == 2'h1);
        end
    end
endmodule
`default_nettype wire

// ### verification/tb_transmit_merge_unit.sv
// Self-checking bench for the four-to-one transmit merge unit
`default_nettype none
module tb_transmit_merge_unit
    import tmu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic slow = 1'b0;
    logic [3:0] src_valid = 4'h0;
    logic [3:0] taken = 4'h0;
    tmu_word_t [3:0] src_word = '0;
    logic [3:0] accept;
    logic mac_valid, mac_ready, mac_last;
    logic stall_q = 1'b0;
    logic [63:0] mac_data;
    logic [64:0] prev_out = '0;
    logic [1:0] sel;
    int error_cnt = 0;
    int total_checks = 0;
    tmu_word_t srcq[4][$];
    tmu_word_t expq[$];
    tmu_word_t gotq[$];

    always #12.5 clock = ~clock;

    transmit_merge_unit i_transmit_merge_unit (.clock(clock), .rst_n(rst_n),
        .source_word_valid(src_valid), .source_word(src_word),
        .source_word_accept(accept), .mac_tx_valid(mac_valid), .mac_tx_ready(mac_ready),
        .mac_tx_data(mac_data), .mac_tx_last(mac_last), .active_channel_select(sel));
    tmu_mac_sink i_tmu_mac_sink (.clock(clock), .rst_n(rst_n), .slow(slow),
        .mac_tx_valid(mac_valid), .mac_tx_ready(mac_ready));

    // ==========================================
    // Helpers
    task automatic chk(input logic [64:0] seen, input logic [64:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Word carries channel and index so order faults show at once
    task automatic pkt(input int c, input int len, input bit want);
        for (int k = 0; k < len; k++) begin
            if (want) expq.push_back({k == len - 1, 32'(c), 32'(k)});
            else srcq[c].push_back({k == len - 1, 32'(c), 32'(k)});
        end
    endtask

    task automatic drain();
        int i;
        i = 0;
        while ((gotq.size() < expq.size() || mac_valid) && i < 2000) begin
            @(negedge clock);
            i++;
        end
        if (i == 2000) begin
            error_cnt++;
            results();
        end
        chk(65'(gotq.size()), 65'(expq.size()));
        for (int k = 0; k < expq.size(); k++) chk(gotq[k], expq[k]);
        gotq.delete();
        expq.delete();
    endtask

    // ==========================================
    // Sources: hold a word until taken; idle lines keep changing
    always @(posedge clock) taken <= src_valid & accept;
    always @(negedge clock) begin
        for (int c = 0; c < 4; c++) begin
            if (taken[c]) void'(srcq[c].pop_front());
            src_valid[c] = (srcq[c].size() != 0);
            src_word[c] = src_valid[c] ? srcq[c][0] : ~src_word[c];
        end
    end

    // ==========================================
    // Port watch: stall hold, accept rules, collect sent words
    always @(negedge clock) begin
        if (rst_n) begin
            if (stall_q) chk(prev_out, {mac_last, mac_data});
            if (stall_q) chk(65'(mac_valid), 65'h1);
            if (stall_q) chk(65'(accept), 65'h0);
            if (accept != 4'h0) chk(65'(accept), 65'(4'h1 << sel));
            if (mac_valid && mac_ready) gotq.push_back({mac_last, mac_data});
        end
        stall_q = mac_valid && !mac_ready;
        prev_out = {mac_last, mac_data};
    end

    // ==========================================
    // Scenarios
    // reset state
    task automatic s_reset();
        chk(65'({accept, mac_valid, sel}), 65'({4'h0, 1'b0, TMU_CH_RESET}));
    endtask

    // two at once from channel 3: 0 before 2
    task automatic s_pair();
        @(posedge clock);
        pkt(0, 2, 0);
        pkt(2, 3, 0);
        pkt(0, 2, 1);
        pkt(2, 3, 1);
        drain();
    endtask

    // all four under stalls, from channel 2
    task automatic s_all_slow();
        slow = 1'b1;
        @(posedge clock);
        pkt(0, 4, 0);
        pkt(1, 2, 0);
        pkt(2, 3, 0);
        pkt(3, 1, 0);
        pkt(3, 1, 1);
        pkt(0, 4, 1);
        pkt(1, 2, 1);
        pkt(2, 3, 1);
        drain();
        slow = 1'b0;
    endtask

    task automatic s_repeat();
        @(posedge clock);
        pkt(1, 1, 0);
        pkt(1, 1, 0);
        pkt(1, 1, 1);
        pkt(1, 1, 1);
        drain();
    endtask

    initial begin
        repeat (6) @(posedge clock);
        @(negedge clock);
        s_reset();
        rst_n = 1'b1;
        s_pair();
        s_all_slow();
        s_repeat();
        results();
    end
endmodule
`default_nettype wire
